// [common/fpc_defs.svh]
// register offsets, field positions, reset values and bandwidth
// scale constants for the filter and pin configuration block.
// assumes nothing; definitions only.
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

// register indexes; byte address is four times the index
`define FPC_IDX_FILT 8'h1E
`define FPC_IDX_BW 8'h1F
`define FPC_IDX_DIR 8'h20
`define FPC_IDX_DATA 8'h21

// field layout
`define FPC_FILT_W 2
`define FPC_BW_LSB 0
`define FPC_BW_MSB 3
`define FPC_NCHAN 4
`define FPC_NPIN 8

// reset values
`define FPC_RST_FILT 8'h00
`define FPC_RST_BW 4'h0
`define FPC_RST_DIR 8'h00
`define FPC_RST_DATA 8'h00

// wideband bandwidth as a fraction of the output data rate, unsigned 0.16
`define FPC_BW_FRAC_WIDE 16'h6ED9
`define FPC_BW_FRAC_NARROW 16'h1BB6

// bus answers
`define FPC_RESP_OKAY 2'h0
`define FPC_RESP_SLVERR 2'h2

`endif

// [common/fpc_pkg.sv]
// types shared by the filter and pin configuration block.
// assumes fpc_defs.svh for the constants; holds types only.
`default_nettype none

package fpc_pkg;

   // per-channel filter choice
   typedef enum logic [1:0] {
      FPC_FILT_WIDE = 2'h0,
      FPC_FILT_SINC6 = 2'h1,
      FPC_FILT_SINC3 = 2'h2,
      FPC_FILT_SINC3_NOTCH = 2'h3
   } fpc_filt_t;

   // decoded register select
   typedef enum logic [2:0] {
      FPC_SEL_NONE = 3'h0,
      FPC_SEL_FILT = 3'h1,
      FPC_SEL_BW = 3'h2,
      FPC_SEL_DIR = 3'h3,
      FPC_SEL_DATA = 3'h4
   } fpc_sel_t;

   // bus channel states
   typedef enum logic {
      FPC_ST_IDLE = 1'b0,
      FPC_ST_RESP = 1'b1
   } fpc_st_t;

   // configuration handed to one channel's filter path
   typedef struct packed {
      fpc_filt_t ftype;
      logic narrow;
      logic [15:0] bw_frac;
   } fpc_chan_cfg_t;

endpackage

`default_nettype wire

// [design/fpc_regs.sv]
// filter type, wideband bandwidth and general pin registers, AXI4-Lite slave.
// assumes a master that keeps valid and payload stable until taken,
// pins sampled synchronously to mclk_i, and a rate generator outside.
//
// Function
// - two-bit filter type per channel, channel 3 at top, 0 at bottom
// - codes select wideband, sinc6, sinc3, sinc3 with 50/60 Hz notch
// - all filter type fields reset to zero, wideband filter
// - one bandwidth bit per channel in bits 3:0, upper bits reserved
// - bandwidth bit 0 gives 0.433, 1 gives 0.10825 times data rate
// - one direction bit per pin, bit n for pin n
// - direction 0 input, 1 output, resets to all inputs
// - input pin data bit reads live level, writes ignored
// - output pin data bit sets driven level, resets to zero
// - data rate is master clock over programmed decimation ratio
`include "fpc_defs.svh"
`default_nettype none

module fpc_regs #(
   parameter int ADDR_W = 12
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output fpc_pkg::fpc_chan_cfg_t [3:0] chan_cfg_o,
   input wire logic [7:0] pin_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_n_o
);

   // register index compare, shared by the read and write paths
   function automatic fpc_pkg::fpc_sel_t fpc_decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-3:0] idx;
      idx = a[ADDR_W-1:2];
      if (idx == (ADDR_W-2)'(`FPC_IDX_FILT)) return fpc_pkg::FPC_SEL_FILT;
      if (idx == (ADDR_W-2)'(`FPC_IDX_BW)) return fpc_pkg::FPC_SEL_BW;
      if (idx == (ADDR_W-2)'(`FPC_IDX_DIR)) return fpc_pkg::FPC_SEL_DIR;
      if (idx == (ADDR_W-2)'(`FPC_IDX_DATA)) return fpc_pkg::FPC_SEL_DATA;
      return fpc_pkg::FPC_SEL_NONE;
   endfunction

   // reset images as vectors, so each field is cut out on purpose
   localparam logic [7:0] RST_FILT = `FPC_RST_FILT;
   localparam logic [3:0] RST_BW = `FPC_RST_BW;

   // write side state
   fpc_pkg::fpc_st_t wst_ff, nxt_wst;
   logic aw_have_ff, nxt_aw_have;
   logic w_have_ff, nxt_w_have;
   logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
   logic [7:0] wbyte_ff, nxt_wbyte;
   logic wlane_ff, nxt_wlane;
   logic awready_ff, nxt_awready;
   logic wready_ff, nxt_wready;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   // configuration state
   fpc_pkg::fpc_chan_cfg_t [3:0] cfg_ff, nxt_cfg;
   logic [7:0] dir_ff, nxt_dir;
   logic [7:0] data_ff, nxt_data;
   logic [7:0] oe_n_ff, nxt_oe_n;
   logic wr_go;
   fpc_pkg::fpc_sel_t wr_sel;
   // read side state
   fpc_pkg::fpc_st_t rst_ff, nxt_rst;
   logic arready_ff, nxt_arready;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;

   // write commits once both address and data are held
   assign wr_go = (wst_ff == fpc_pkg::FPC_ST_IDLE) && aw_have_ff && w_have_ff;
   assign wr_sel = fpc_decode(awaddr_ff);

   // write channels and register updates
   always_comb begin
      nxt_wst = wst_ff;
      nxt_aw_have = aw_have_ff;
      nxt_w_have = w_have_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wbyte = wbyte_ff;
      nxt_wlane = wlane_ff;
      nxt_awready = awready_ff;
      nxt_wready = wready_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_cfg = cfg_ff;
      nxt_dir = dir_ff;
      nxt_data = data_ff;
      case (wst_ff)
         fpc_pkg::FPC_ST_IDLE: begin
            // address and data may arrive in either order
            if (s_axi_awvalid_i && awready_ff) begin
               nxt_awaddr = s_axi_awaddr_i;
               nxt_aw_have = 1'b1;
               nxt_awready = 1'b0;
            end
            if (s_axi_wvalid_i && wready_ff) begin
               nxt_wbyte = s_axi_wdata_i[7:0];
               nxt_wlane = s_axi_wstrb_i[0];
               nxt_w_have = 1'b1;
               nxt_wready = 1'b0;
            end
            if (wr_go) begin
               nxt_aw_have = 1'b0;
               nxt_w_have = 1'b0;
               nxt_bvalid = 1'b1;
               nxt_bresp = `FPC_RESP_OKAY;
               nxt_wst = fpc_pkg::FPC_ST_RESP;
               // only byte lane 0 carries register bits
               if (wlane_ff) begin
                  case (wr_sel)
                     fpc_pkg::FPC_SEL_FILT: begin
                        for (int c = 0; c < `FPC_NCHAN; c++) begin
                           nxt_cfg[c].ftype =
                              fpc_pkg::fpc_filt_t'(wbyte_ff[2*c +: `FPC_FILT_W]);
                        end
                     end
                     fpc_pkg::FPC_SEL_BW: begin
                        // bits 7:4 dropped so reserved stays zero
                        for (int c = 0; c < `FPC_NCHAN; c++) begin
                           nxt_cfg[c].narrow = wbyte_ff[c];
                        end
                     end
                     fpc_pkg::FPC_SEL_DIR: begin
                        nxt_dir = wbyte_ff;
                     end
                     fpc_pkg::FPC_SEL_DATA: begin
                        // input pins keep their stored bit
                        nxt_data = (data_ff & ~dir_ff) | (wbyte_ff & dir_ff);
                     end
                     default: begin
                        nxt_bresp = `FPC_RESP_SLVERR;
                     end
                  endcase
               end else if (wr_sel == fpc_pkg::FPC_SEL_NONE) begin
                  nxt_bresp = `FPC_RESP_SLVERR;
               end
            end
         end
         fpc_pkg::FPC_ST_RESP: begin
            if (s_axi_bready_i) begin
               nxt_bvalid = 1'b0;
               nxt_awready = 1'b1;
               nxt_wready = 1'b1;
               nxt_wst = fpc_pkg::FPC_ST_IDLE;
            end
         end
         default: begin
            nxt_wst = fpc_pkg::FPC_ST_IDLE;
         end
      endcase
      // scale is relative to output_data_rate, which the rate generator
      // derives as mclk over the decimation ratio
      for (int c = 0; c < `FPC_NCHAN; c++) begin
         nxt_cfg[c].bw_frac = nxt_cfg[c].narrow ? `FPC_BW_FRAC_NARROW
                                                : `FPC_BW_FRAC_WIDE;
      end
      // pin driver enable is low while driving
      nxt_oe_n = ~nxt_dir;
   end

   // write side registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wst_ff <= fpc_pkg::FPC_ST_IDLE;
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awaddr_ff <= '0;
         wbyte_ff <= 8'h00;
         wlane_ff <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= `FPC_RESP_OKAY;
         for (int c = 0; c < `FPC_NCHAN; c++) begin
            cfg_ff[c].ftype <= fpc_pkg::fpc_filt_t'(RST_FILT[2*c +: `FPC_FILT_W]);
            cfg_ff[c].narrow <= RST_BW[c];
            cfg_ff[c].bw_frac <= `FPC_BW_FRAC_WIDE;
         end
         dir_ff <= `FPC_RST_DIR;
         data_ff <= `FPC_RST_DATA;
         oe_n_ff <= ~`FPC_RST_DIR;
      end else begin
         wst_ff <= nxt_wst;
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         awaddr_ff <= nxt_awaddr;
         wbyte_ff <= nxt_wbyte;
         wlane_ff <= nxt_wlane;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         cfg_ff <= nxt_cfg;
         dir_ff <= nxt_dir;
         data_ff <= nxt_data;
         oe_n_ff <= nxt_oe_n;
      end
   end

   // read channel; data latched at the taking edge
   always_comb begin
      nxt_rst = rst_ff;
      nxt_arready = arready_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      case (rst_ff)
         fpc_pkg::FPC_ST_IDLE: begin
            if (s_axi_arvalid_i) begin
               nxt_rdata = 32'h0000_0000;
               nxt_rresp = `FPC_RESP_OKAY;
               case (fpc_decode(s_axi_araddr_i))
                  fpc_pkg::FPC_SEL_FILT: begin
                     for (int c = 0; c < `FPC_NCHAN; c++) begin
                        nxt_rdata[2*c +: `FPC_FILT_W] = cfg_ff[c].ftype;
                     end
                  end
                  fpc_pkg::FPC_SEL_BW: begin
                     for (int c = 0; c < `FPC_NCHAN; c++) begin
                        nxt_rdata[c] = cfg_ff[c].narrow;
                     end
                  end
                  fpc_pkg::FPC_SEL_DIR: begin
                     nxt_rdata[7:0] = dir_ff;
                  end
                  fpc_pkg::FPC_SEL_DATA: begin
                     // inputs show the live level, outputs the driven bit
                     nxt_rdata[7:0] = (data_ff & dir_ff) | (pin_i & ~dir_ff);
                  end
                  default: begin
                     nxt_rresp = `FPC_RESP_SLVERR;
                  end
               endcase
               nxt_rvalid = 1'b1;
               nxt_arready = 1'b0;
               nxt_rst = fpc_pkg::FPC_ST_RESP;
            end
         end
         fpc_pkg::FPC_ST_RESP: begin
            if (s_axi_rready_i) begin
               nxt_rvalid = 1'b0;
               nxt_arready = 1'b1;
               nxt_rst = fpc_pkg::FPC_ST_IDLE;
            end
         end
         default: begin
            nxt_rst = fpc_pkg::FPC_ST_IDLE;
         end
      endcase
   end

   // read side registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_ff <= fpc_pkg::FPC_ST_IDLE;
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `FPC_RESP_OKAY;
      end else begin
         rst_ff <= nxt_rst;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // outputs straight from flops
   assign s_axi_awready_o = awready_ff;
   assign s_axi_wready_o = wready_ff;
   assign s_axi_bvalid_o = bvalid_ff;
   assign s_axi_bresp_o = bresp_ff;
   assign s_axi_arready_o = arready_ff;
   assign s_axi_rvalid_o = rvalid_ff;
   assign s_axi_rdata_o = rdata_ff;
   assign s_axi_rresp_o = rresp_ff;
   assign chan_cfg_o = cfg_ff;
   assign pin_o = data_ff;
   assign pin_oe_n_o = oe_n_ff;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // filter type write lands in the channel 3 and channel 0 fields
   property p_filt_write;
      wr_go && wlane_ff && wr_sel == fpc_pkg::FPC_SEL_FILT |=>
         chan_cfg_o[3].ftype == $past(wbyte_ff[7:6]) &&
         chan_cfg_o[0].ftype == $past(wbyte_ff[1:0]);
   endproperty
   a_filt_write: assert property (p_filt_write) else $error("filter type not stored");

   // sinc6 code reaches a channel as the sinc6 choice
   property p_filt_code;
      wr_go && wlane_ff && wr_sel == fpc_pkg::FPC_SEL_FILT && wbyte_ff[3:2] == 2'h1 |=>
         chan_cfg_o[1].ftype == fpc_pkg::FPC_FILT_SINC6;
   endproperty
   a_filt_code: assert property (p_filt_code) else $error("filter code mismatch");

   // bandwidth fraction follows the narrow bit
   property p_bw_frac;
      chan_cfg_o[2].bw_frac == (chan_cfg_o[2].narrow ? `FPC_BW_FRAC_NARROW : `FPC_BW_FRAC_WIDE);
   endproperty
   a_bw_frac: assert property (p_bw_frac) else $error("bandwidth scale wrong");

   // reserved read bits stay zero
   property p_rd_reserved;
      s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000;
   endproperty
   a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bits set");

   // direction write steers the driver enables
   property p_dir_oe;
      wr_go && wlane_ff && wr_sel == fpc_pkg::FPC_SEL_DIR |=>
         ##1 pin_oe_n_o == ~$past(wbyte_ff, 2);
   endproperty
   a_dir_oe: assert property (p_dir_oe) else $error("driver enable wrong");

   // input pins keep their data bit through a write
   property p_pin_in_hold;
      wr_go && wlane_ff && wr_sel == fpc_pkg::FPC_SEL_DATA |=>
         ((pin_o ^ $past(pin_o)) & ~$past(dir_ff)) == 8'h00;
   endproperty
   a_pin_in_hold: assert property (p_pin_in_hold) else $error("input pin bit changed");

   // output pins take the written level
   property p_pin_drive;
      wr_go && wlane_ff && wr_sel == fpc_pkg::FPC_SEL_DATA |=>
         (pin_o & $past(dir_ff)) == ($past(wbyte_ff) & $past(dir_ff));
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("output level wrong");

   // write answer stands until taken, with its response code unchanged
   property p_bresp_hold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o ##0 $stable(s_axi_bresp_o);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");

endmodule // fpc_regs

`default_nettype wire

// [bench/fpc_pin_model.sv]
// outside circuitry on the eight general pins: drives only undriven pins.
// assumes the bench supplies the outside levels, synchronous to mclk_i.
`default_nettype none

module fpc_pin_model (
   input wire logic [7:0] dev_lvl_i,
   input wire logic [7:0] dev_oe_n_i,
   input wire logic [7:0] ext_lvl_i,
   output logic [7:0] pin_lvl_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // wire level per pin; outside driver backs off where the device drives
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         pin_lvl_o[n] = dev_oe_n_i[n] ? ext_lvl_i[n] : dev_lvl_i[n];
      end
   end
endmodule // fpc_pin_model

`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the filter and pin configuration registers.
// assumes fpc_regs with a 12-bit AXI4-Lite slave and the pin model beside it.
`include "fpc_defs.svh"
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk_i, rst_i, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [3:0] ws;
   logic [1:0] bresp, rresp;
   fpc_pkg::fpc_chan_cfg_t [3:0] cfg;
   logic [7:0] pin_in, pin_out, pin_oe_n, ext, lfsr_q, v, r, d, s, e;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int fail_count, checked;

   fpc_regs #(.ADDR_W(12)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rr), .chan_cfg_o(cfg), .pin_i(pin_in), .pin_o(pin_out),
      .pin_oe_n_o(pin_oe_n));

   fpc_pin_model i_pins (.dev_lvl_i(pin_out), .dev_oe_n_i(pin_oe_n), .ext_lvl_i(ext),
      .pin_lvl_o(pin_in));

   // 40 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   function logic [7:0] rnd();
      lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      return lfsr_q;
   endfunction

   function logic [11:0] ad(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

   // one compare per kind of result; each counts and reports its own mismatch
   task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: read answer %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_wr(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: write answer %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_cfg(input logic [18:0] got, input logic [18:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: channel setup %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: pin outputs %h expected %h", $time, got, exp);
      end
   endtask

   task tally_and_finish();
      if (fail_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task timed_out();
      fail_count++;
      $display("mismatch at %0t: handshake wait ran out", $time);
      tally_and_finish();
   endtask

   // write one byte; holds each channel until its own handshake edge
   task wr(input logic [11:0] a, input logic [7:0] dat, input logic [1:0] er);
      int n;
      bq.push_back(er);
      @(posedge mclk_i);
      awa <= a;
      awv <= 1'b1;
      wd <= {24'h0, dat};
      ws <= 4'h1;
      wv <= 1'b1;
      br <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk_i);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_rdy) wv <= 1'b0;
         if (bv) break;
      end
      br <= 1'b0;
      if (n == 50) timed_out();
   endtask

   // read one register and note the expected answer
   task rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
      int n;
      rq.push_back({er, 24'h0, exp});
      @(posedge mclk_i);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk_i);
         if (arv && arr) arv <= 1'b0;
         if (rv) break;
      end
      rr <= 1'b0;
      if (n == 50) timed_out();
   endtask

   // per-channel configuration outputs against filter codes and narrow bits
   task chk_cfg(input logic [7:0] ft, input logic [3:0] nb);
      logic [15:0] bw;
      @(negedge mclk_i);
      for (int c = 0; c < 4; c++) begin
         bw = nb[c] ? `FPC_BW_FRAC_NARROW : `FPC_BW_FRAC_WIDE;
         cmp_cfg(cfg[c], {ft[2*c+:2], nb[c], bw});
      end
   endtask

   // answers are compared in the order they were requested; an unasked one is a fault
   always @(posedge mclk_i) begin
      if (rv === 1'b1 && rr === 1'b1) begin
         if (rq.size() == 0) begin
            fail_count++;
            $display("mismatch at %0t: read answer with nothing expected", $time);
         end else begin
            cmp_rd({rresp, rdat}, rq.pop_front());
         end
      end
      if (bv === 1'b1 && br === 1'b1) begin
         if (bq.size() == 0) begin
            fail_count++;
            $display("mismatch at %0t: write answer with nothing expected", $time);
         end else begin
            cmp_wr(bresp, bq.pop_front());
         end
      end
   end

   initial begin
      lfsr_q = 8'h61;
      rst_i = 1'b1;
      {awv, wv, br, arv, rr} = 5'h00;
      awa = 12'h000;
      ara = 12'h000;
      wd = 32'h0;
      ws = 4'h0;
      ext = 8'h00;
      s = 8'h00;
      fail_count = 0;
      checked = 0;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      e = rnd();
      ext <= e;
      chk_cfg(8'h00, 4'h0);
      cmp_pin(pin_oe_n, 8'hFF);
      cmp_pin(pin_out, 8'h00);
      rd(ad(`FPC_IDX_FILT), 8'h00, `FPC_RESP_OKAY);
      rd(ad(`FPC_IDX_BW), 8'h00, `FPC_RESP_OKAY);
      rd(ad(`FPC_IDX_DIR), 8'h00, `FPC_RESP_OKAY);
      rd(ad(`FPC_IDX_DATA), e, `FPC_RESP_OKAY);
      // every code on every channel, rotated so fields differ
      for (int c = 0; c < 4; c++) begin
         v = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
         wr(ad(`FPC_IDX_FILT), v, `FPC_RESP_OKAY);
         chk_cfg(v, 4'h0);
         rd(ad(`FPC_IDX_FILT), v, `FPC_RESP_OKAY);
      end
      wr(ad(`FPC_IDX_BW), 8'hFF, `FPC_RESP_OKAY);
      rd(ad(`FPC_IDX_BW), 8'h0F, `FPC_RESP_OKAY);
      chk_cfg(v, 4'hF);
      wr(ad(`FPC_IDX_BW), 8'h05, `FPC_RESP_OKAY);
      chk_cfg(v, 4'h5);
      // mixed directions: stored bits move only where the pin is an output
      repeat (5) begin
         r = rnd();
         d = rnd();
         wr(ad(`FPC_IDX_DIR), r, `FPC_RESP_OKAY);
         wr(ad(`FPC_IDX_DATA), d, `FPC_RESP_OKAY);
         s = (s & ~r) | (d & r);
         e = rnd();
         ext <= e;
         @(negedge mclk_i);
         cmp_pin(pin_oe_n, ~r);
         cmp_pin(pin_out, s);
         rd(ad(`FPC_IDX_DATA), (r & s) | (~r & e), `FPC_RESP_OKAY);
         rd(ad(`FPC_IDX_DIR), r, `FPC_RESP_OKAY);
      end
      // unmapped word just past the pin value register
      wr(12'h088, 8'hAA, `FPC_RESP_SLVERR);
      rd(12'h088, 8'h00, `FPC_RESP_SLVERR);
      rd(ad(`FPC_IDX_BW), 8'h05, `FPC_RESP_OKAY);
      // reset again in mid-run: every written field must fall back
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk_cfg(8'h00, 4'h0);
      cmp_pin(pin_oe_n, 8'hFF);
      cmp_pin(pin_out, 8'h00);
      rd(ad(`FPC_IDX_DIR), 8'h00, `FPC_RESP_OKAY);
      rd(ad(`FPC_IDX_BW), 8'h00, `FPC_RESP_OKAY);
      repeat (4) @(posedge mclk_i);
      tally_and_finish();
   end
endmodule // tb_top

`default_nettype wire
